// ---- src/pin_ctrl.sv ----
// Purpose: Peripheral data bus, halt, interrupt, reset vector and user pin control
// Assumes: One 100 MHz clock CLOCK; RST_N synchronous active low stands for the reset pin
// Notes:   Software drives accesses and core events through APB registers
// Function
// R1 - Data lines float except during external writes
// R2 - Direction low while driving, high otherwise
// R3 - Latched three-bit select picks eight registers
// R4 - Selects four to seven internal when enabled
// R5 - Peripheral captures write data on strobe rise
// R6 - Read data sampled on clock edge
// R7 - Halt holds program counter, executes no-ops
// R8 - Halt driver changes synchronously with clock
// R9 - Halt left only through interrupt service
// R10 - Interrupt inputs trigger on rising edge
// R11 - Service address fetched from top vector words
// R12 - Fixed priority: zero, one, then two
// R13 - Codec owns irq one, timer irq two
// R14 - Reset held low at least one cycle
// R15 - Reset release pushes PC, loads reset vector
// R16 - Ready waiting stretches strobe, holds lines
// R17 - Ready sampled only during external access
// R18 - Configured accesses get one internal wait
// R19 - General inputs appear as status bits
// R20 - General outputs drive inverse of status
// R21 - General output zero signals radio controller
// R22 - Ready high adds further wait states
// R23 - Read and write waits set per register
// R24 - General inputs pass two-stage synchronizer
// R25 - Pending interrupt cleared at vector fetch
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps

module pin_ctrl
  import pin_ctrl_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic              RST_N,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic [15:0]       PERIPH_DATA_BUS_I,
  output logic      [15:0]       PERIPH_DATA_BUS_O,
  output logic                   PERIPH_DATA_BUS_OE,
  output logic                   PERIPH_BUS_DIR,
  output logic      [2:0]        PERIPH_REG_SELECT,
  output logic                   PERIPH_ACCESS_STROBE_N,
  input  wire logic              PERIPH_READY_N,
  input  wire logic              HALT,
  input  wire logic [2:0]        EXT_IRQ_N,
  input  wire logic              CODEC_IRQ,
  input  wire logic              TIMER_IRQ,
  input  wire logic [1:0]        GENERAL_INPUTS,
  output logic      [1:0]        GENERAL_OUTPUTS
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    acc_state_t                         acc_state;
    logic [2:0]                         sel;
    logic                               write;
    logic                               internal;
    logic [15:0]                        wdata;
    logic [15:0]                        rdata;
    logic                               strobe_n;
    logic                               dir;
    logic                               oe;
    logic                               codec_en;
    logic                               timer_en;
    logic [2:0]                         irq_en;
    logic [15:0]                        wait_cfg;
    logic [1:0]                         gout;
    logic [2:0]                         pend;
    logic [11:0]                        pc;
    logic [STACK_ENTRIES-1:0][11:0]     stack;
    logic [2:0]                         sp;
    logic                               halted;
    logic                               in_svc;
    boot_t                              boot;
    logic [3:0][11:0]                   vec;
    logic                               halt_m;
    logic                               halt_s;
    logic                               halt_p;
    logic [2:0]                         irq_m;
    logic [2:0]                         irq_s;
    logic [2:0]                         irq_p;
    logic                               rdy_m;
    logic                               rdy_s;
    logic [1:0]                         gin_m;
    logic [1:0]                         gin_s;
    logic [15:0]                        din_m;
    logic [15:0]                        din_s;
  } state_t;

  // Interrupt and ready synchronisers idle high at reset so no false edge or false ready appears
  localparam state_t RESET_STATE = '{
    acc_state: ACC_IDLE,
    boot:      BOOT_PUSH,
    strobe_n:  1'b1,
    dir:       1'b1,
    wait_cfg:  WAIT_RESET,
    pc:        PC_RESET,
    vec:       {4{VEC_WORD_RESET}},
    irq_m:     3'h7,
    irq_s:     3'h7,
    irq_p:     3'h7,
    rdy_m:     1'b1,
    rdy_s:     1'b1,
    default:   '0
  };

  state_t      s;
  state_t      d;
  logic        busy;
  logic        apb_acc;
  logic        wr_en;
  logic        mapped;
  logic        vec_hit;
  logic [1:0]  vec_idx;
  logic [2:0]  ext_rise;
  logic [2:0]  src;
  logic [2:0]  clr;
  logic [2:0]  take;
  logic [11:0] take_vec;
  logic        svc;
  logic        wait_bit;
  logic        reserved;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  // A new access is stalled while one is running, so the request is never lost
  assign busy    = (s.acc_state != ACC_IDLE);
  assign apb_acc = PSEL & PENABLE;
  assign PREADY  = ~(apb_acc & PWRITE & (PADDR == REG_ACCESS) & busy);
  assign wr_en   = apb_acc & PWRITE & PREADY;
  assign vec_hit = (PADDR[11:4] == REG_VEC[11:4]) & (PADDR[1:0] == 2'b00);
  assign vec_idx = PADDR[3:2];
  assign mapped  = vec_hit | (PADDR == REG_CTRL) | (PADDR == REG_STATUS)
                 | (PADDR == REG_WAIT) | (PADDR == REG_ACCESS) | (PADDR == REG_RDATA)
                 | (PADDR == REG_IRQ) | (PADDR == REG_CORE) | (PADDR == REG_CMD);
  assign PSLVERR = apb_acc & PREADY & ~mapped;

  // Read mux; unmapped and reserved bits read as zero
  always_comb begin
    PRDATA = 32'h0000_0000;
    if (vec_hit) begin
      PRDATA[11:0] = s.vec[vec_idx];
    end else begin
      unique case (PADDR)
        REG_CTRL: begin
          PRDATA[CTRL_CODEC_EN_BIT]                  = s.codec_en;
          PRDATA[CTRL_TIMER_EN_BIT]                  = s.timer_en;
          PRDATA[CTRL_IRQ_EN_LSB +: 3]               = s.irq_en;
        end
        REG_STATUS: begin
          PRDATA[STATUS_GEN_OUT0]                    = s.gout[0];
          PRDATA[STATUS_GEN_OUT1]                    = s.gout[1];
          // R19 status inputs
          PRDATA[STATUS_GEN_IN0]                     = s.gin_s[0];
          PRDATA[STATUS_GEN_IN1]                     = s.gin_s[1];
        end
        REG_WAIT:   PRDATA[15:0]                     = s.wait_cfg;
        REG_ACCESS: begin
          PRDATA[ACC_SEL_LSB +: 3]                   = s.sel;
          PRDATA[ACC_WRITE_BIT]                      = s.write;
          PRDATA[ACC_BUSY_BIT]                       = busy;
          PRDATA[ACC_INTERNAL_BIT]                   = s.internal;
          PRDATA[ACC_WDATA_LSB +: 16]                = s.wdata;
        end
        REG_RDATA:  PRDATA[15:0]                     = s.rdata;
        REG_IRQ:    PRDATA[2:0]                      = s.pend;
        REG_CORE: begin
          PRDATA[CORE_PC_LSB +: 12]                  = s.pc;
          PRDATA[CORE_HALTED_BIT]                    = s.halted;
          PRDATA[CORE_INSVC_BIT]                     = s.in_svc;
          PRDATA[CORE_SP_LSB +: 3]                   = s.sp;
        end
        default:    PRDATA                           = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Interrupt sources
  // ---------------------------------------------------------------
  // R10 edge detect on release of the active-low pin
  assign ext_rise = s.irq_s & ~s.irq_p;
  // R13 internal peripherals take over lines one and two when enabled
  assign src[0] = ext_rise[0];
  assign src[1] = s.codec_en ? CODEC_IRQ : ext_rise[1];
  assign src[2] = s.timer_en ? TIMER_IRQ : ext_rise[2];
  assign clr    = (wr_en && PADDR == REG_IRQ) ? PWDATA[2:0] : 3'h0;

  // R12 fixed priority pick with R11 vector lookup
  always_comb begin
    take     = 3'h0;
    take_vec = s.vec[VEC_IRQ2_ADDR[1:0]];
    if (s.pend[0] & s.irq_en[0]) begin
      take[0]  = 1'b1;
      take_vec = s.vec[VEC_IRQ0_ADDR[1:0]];
    end else if (s.pend[1] & s.irq_en[1]) begin
      take[1]  = 1'b1;
      take_vec = s.vec[VEC_IRQ1_ADDR[1:0]];
    end else if (s.pend[2] & s.irq_en[2]) begin
      take[2]  = 1'b1;
      take_vec = s.vec[VEC_IRQ2_ADDR[1:0]];
    end
  end

  // Service needs a free stack slot; nesting is not allowed
  assign svc = (|take) & ~s.in_svc & (s.boot == BOOT_DONE)
             & (s.sp < 3'(STACK_ENTRIES));

  // R18 R23 per-register, per-direction wait bit
  assign wait_bit = s.write ? s.wait_cfg[WAIT_WR_LSB + 32'(s.sel)]
                            : s.wait_cfg[WAIT_RD_LSB + 32'(s.sel)];
  // R4 upper selects belong to internal peripherals when both are enabled
  assign reserved = s.codec_en & s.timer_en & PWDATA[ACC_SEL_LSB + 2];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d = s;

    // R24 two-stage synchronisers; first stage feeds only the second
    d.halt_m = HALT;
    d.halt_s = s.halt_m;
    d.halt_p = s.halt_s;
    d.irq_m  = EXT_IRQ_N;
    d.irq_s  = s.irq_m;
    d.irq_p  = s.irq_s;
    d.rdy_m  = PERIPH_READY_N;
    d.rdy_s  = s.rdy_m;
    d.gin_m  = GENERAL_INPUTS;
    d.gin_s  = s.gin_m;
    d.din_m  = PERIPH_DATA_BUS_I;
    d.din_s  = s.din_m;

    // Software register writes
    if (wr_en) begin
      if (vec_hit) begin
        d.vec[vec_idx] = PWDATA[11:0];
      end
      if (PADDR == REG_CTRL) begin
        d.codec_en = PWDATA[CTRL_CODEC_EN_BIT];
        d.timer_en = PWDATA[CTRL_TIMER_EN_BIT];
        d.irq_en   = PWDATA[CTRL_IRQ_EN_LSB +: 3];
      end
      if (PADDR == REG_STATUS) begin
        d.gout[0] = PWDATA[STATUS_GEN_OUT0];
        d.gout[1] = PWDATA[STATUS_GEN_OUT1];
      end
      if (PADDR == REG_WAIT) begin
        d.wait_cfg = PWDATA[15:0];
      end
    end

    // R25 pending held until vector fetch; a new edge wins over any clear
    d.pend = (s.pend & ~clr & ~(svc ? take : 3'h0)) | src;

    // Program counter sequencing
    if (s.boot == BOOT_PUSH) begin
      // R15 push current PC first
      d.stack[s.sp] = s.pc;
      d.sp          = s.sp + 3'h1;
      d.boot        = BOOT_LOAD;
    end else if (s.boot == BOOT_LOAD) begin
      // R15 then load the reset vector
      d.pc   = s.vec[VEC_RESET_ADDR[1:0]];
      d.boot = BOOT_DONE;
    end else if (svc) begin
      // R9 R11 service pushes return point and leaves halt
      d.stack[s.sp] = s.pc;
      d.sp          = s.sp + 3'h1;
      d.pc          = take_vec;
      d.halted      = 1'b0;
      d.in_svc      = 1'b1;
    end else if (wr_en && PADDR == REG_CMD && PWDATA[CMD_RETURN_BIT] && s.sp != 3'h0) begin
      // Return resumes after the halt, as the pushed PC already points there
      d.pc     = s.stack[s.sp - 3'h1];
      d.sp     = s.sp - 3'h1;
      d.in_svc = 1'b0;
    end else if (s.halt_s & ~s.halt_p) begin
      // R7 halt entry stops the PC
      d.halted = 1'b1;
    end else if (!s.halted) begin
      d.pc = s.pc + 12'h001;
    end

    // External access sequencer
    unique case (s.acc_state)
      ACC_IDLE: begin
        if (wr_en && PADDR == REG_ACCESS) begin
          // R3 select latched and held after the access
          d.sel      = PWDATA[ACC_SEL_LSB +: 3];
          d.write    = PWDATA[ACC_WRITE_BIT];
          d.wdata    = PWDATA[ACC_WDATA_LSB +: 16];
          d.internal = reserved;
          if (reserved) begin
            // R4 internal slot raises no strobe and drives no data; only the select pins and the undriven data value follow
            d.rdata = 16'h0000;
          end else begin
            d.acc_state = ACC_SETUP;
            d.strobe_n  = 1'b0;
            // R2 direction low only while driving
            d.dir       = ~PWDATA[ACC_WRITE_BIT];
            // R1 data lines driven only for writes
            d.oe        = PWDATA[ACC_WRITE_BIT];
          end
        end
      end
      ACC_SETUP: begin
        d.acc_state = ACC_READY;
      end
      ACC_READY, ACC_WAIT: begin
        // R17 R22 ready looked at only in READY; high keeps waiting
        // R16 strobe, direction, select and data stay put meanwhile
        if (s.acc_state == ACC_READY && !s.rdy_s && wait_bit) begin
          // R18 wait after ready, so sync latency cannot hide it
          d.acc_state = ACC_WAIT;
        end else if (s.acc_state == ACC_WAIT || !s.rdy_s) begin
          // R6 read data taken on the clock edge, not the strobe
          if (!s.write) begin
            d.rdata = s.din_s;
          end
          d.acc_state = ACC_IDLE;
          // R5 strobe rises in the same cycle that data drive and direction are released
          d.strobe_n  = 1'b1;
          d.dir       = 1'b1;
          d.oe        = 1'b0;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // R14 synchronous reset; one low edge is enough to load reset state
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      s <= RESET_STATE;
    end else begin
      s <= d;
    end
  end

  // ---------------------------------------------------------------
  // Pin outputs
  // ---------------------------------------------------------------
  // Data lines keep the data field of the last access request, read or write; only the enable floats them
  assign PERIPH_DATA_BUS_O      = s.wdata;
  assign PERIPH_DATA_BUS_OE     = s.oe;
  assign PERIPH_BUS_DIR         = s.dir;
  assign PERIPH_REG_SELECT      = s.sel;
  assign PERIPH_ACCESS_STROBE_N = s.strobe_n;
  // R20 R21 pins carry inverse of status; output zero alerts the radio controller
  assign GENERAL_OUTPUTS        = ~s.gout;

endmodule

// ---- src/pin_ctrl_pkg.sv ----
// Purpose: Shared constants and types for the peripheral bus and pin control block
// Assumes: APB slave with 32-bit data, 12-bit byte addresses, one word per register
// Notes:   Vector addresses index a four-word table held in this block
package pin_ctrl_pkg;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam int             ADDR_W      = 12;
  localparam logic [11:0]    REG_CTRL    = 12'h000;
  localparam logic [11:0]    REG_STATUS  = 12'h004;
  localparam logic [11:0]    REG_WAIT    = 12'h008;
  localparam logic [11:0]    REG_ACCESS  = 12'h00c;
  localparam logic [11:0]    REG_RDATA   = 12'h010;
  localparam logic [11:0]    REG_IRQ     = 12'h014;
  localparam logic [11:0]    REG_CORE    = 12'h018;
  localparam logic [11:0]    REG_CMD     = 12'h01c;
  localparam logic [11:0]    REG_VEC     = 12'h020;  // Four words, 0x020..0x02c

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_CODEC_EN_BIT = 0;
  localparam int CTRL_TIMER_EN_BIT = 1;
  localparam int CTRL_IRQ_EN_LSB   = 2;
  localparam int STATUS_GEN_OUT0   = 5;
  localparam int STATUS_GEN_OUT1   = 6;
  localparam int STATUS_GEN_IN0    = 10;
  localparam int STATUS_GEN_IN1    = 11;
  localparam int WAIT_RD_LSB       = 0;
  localparam int WAIT_WR_LSB       = 8;
  localparam int ACC_SEL_LSB       = 0;
  localparam int ACC_WRITE_BIT     = 3;
  localparam int ACC_BUSY_BIT      = 4;
  localparam int ACC_INTERNAL_BIT  = 5;
  localparam int ACC_WDATA_LSB     = 16;
  localparam int CORE_PC_LSB       = 0;
  localparam int CORE_HALTED_BIT   = 12;
  localparam int CORE_INSVC_BIT    = 13;
  localparam int CORE_SP_LSB       = 16;
  localparam int CMD_RETURN_BIT    = 0;

  // ---------------------------------------------------------------
  // Vector locations and reset values
  // ---------------------------------------------------------------
  localparam logic [11:0] VEC_RESET_ADDR = 12'hffc;
  localparam logic [11:0] VEC_IRQ0_ADDR  = 12'hffd;
  localparam logic [11:0] VEC_IRQ1_ADDR  = 12'hffe;
  localparam logic [11:0] VEC_IRQ2_ADDR  = 12'hfff;
  localparam logic [11:0] VEC_WORD_RESET = 12'h000;
  localparam logic [11:0] PC_RESET       = 12'h000;
  localparam logic [15:0] WAIT_RESET     = 16'h0000;
  localparam int          STACK_ENTRIES  = 6;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_SETUP = 2'b01,
    ACC_WAIT  = 2'b11,
    ACC_READY = 2'b10
  } acc_state_t;

  typedef enum logic [1:0] {
    BOOT_DONE = 2'b00,
    BOOT_PUSH = 2'b01,
    BOOT_LOAD = 2'b11
  } boot_t;

endpackage

// ---- test/pin_ctrl_sva.sv ----
// Purpose: Port assertions for the peripheral bus and pin control block
// Assumes: One clock CLOCK, RST_N synchronous active low
// Notes:   Bound to pin_ctrl below the module
`timescale 1ns/1ps
module pin_ctrl_sva
  import pin_ctrl_pkg::*;
(
  input wire logic              CLOCK,
  input wire logic              RST_N,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0]       PWDATA,
  input wire logic              PREADY,
  input wire logic [15:0]       PERIPH_DATA_BUS_O,
  input wire logic              PERIPH_DATA_BUS_OE,
  input wire logic              PERIPH_BUS_DIR,
  input wire logic [2:0]        PERIPH_REG_SELECT,
  input wire logic              PERIPH_ACCESS_STROBE_N,
  input wire logic              PERIPH_READY_N,
  input wire logic [1:0]        GENERAL_OUTPUTS
);
  // ---------------------------------------------------------------
  // Helpers and properties
  // ---------------------------------------------------------------
  logic acc_wr;
  logic st_wr;
  // Accepted writes are the only legal cause of pin activity
  assign acc_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == REG_ACCESS;
  assign st_wr  = PSEL && PENABLE && PREADY && PWRITE && PADDR == REG_STATUS;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  property p_float;
    PERIPH_DATA_BUS_OE |-> !PERIPH_ACCESS_STROBE_N;
  endproperty
  a_float: assert property (p_float) else $error("data driven outside an access");
  property p_dir;
    PERIPH_BUS_DIR == !PERIPH_DATA_BUS_OE;
  endproperty
  a_dir: assert property (p_dir) else $error("direction disagrees with drive");
  // Low selects only, so the internal slots never reach the pins here
  property p_start;
    acc_wr && !PWDATA[2] |=> !PERIPH_ACCESS_STROBE_N
      && PERIPH_REG_SELECT == $past(PWDATA[2:0]) && PERIPH_BUS_DIR == !$past(PWDATA[3])
      && (PERIPH_BUS_DIR || PERIPH_DATA_BUS_O == $past(PWDATA[31:16]));
  endproperty
  a_start: assert property (p_start) else $error("access start pins wrong");
  property p_hold;
    !PERIPH_ACCESS_STROBE_N && !$past(PERIPH_ACCESS_STROBE_N)
      |-> $stable(PERIPH_REG_SELECT) && $stable(PERIPH_DATA_BUS_O);
  endproperty
  a_hold: assert property (p_hold) else $error("select or data moved in access");
  // Two sync flops: three high samples cannot have ended the access yet
  property p_stretch;
    (!PERIPH_ACCESS_STROBE_N && PERIPH_READY_N) [*3] |=> !PERIPH_ACCESS_STROBE_N;
  endproperty
  a_stretch: assert property (p_stretch) else $error("strobe ended while not ready");
  property p_min;
    $fell(PERIPH_ACCESS_STROBE_N) |-> !PERIPH_ACCESS_STROBE_N [*2];
  endproperty
  a_min: assert property (p_min) else $error("strobe shorter than two cycles");
  property p_cause;
    $fell(PERIPH_ACCESS_STROBE_N) |-> $past(acc_wr);
  endproperty
  a_cause: assert property (p_cause) else $error("strobe without access request");
  property p_gout;
    st_wr |=> GENERAL_OUTPUTS == ~$past(PWDATA[6:5]);
  endproperty
  a_gout: assert property (p_gout) else $error("general outputs not inverted");
  property p_gkeep;
    $changed(GENERAL_OUTPUTS) |-> $past(st_wr);
  endproperty
  a_gkeep: assert property (p_gkeep) else $error("general output moved alone");

  c_acc: cover property (acc_wr ##1 !PERIPH_ACCESS_STROBE_N);
  c_wait: cover property ((!PERIPH_ACCESS_STROBE_N && PERIPH_READY_N) [*3]);
  c_gout: cover property (st_wr);
endmodule

bind pin_ctrl pin_ctrl_sva u_pin_ctrl_sva (
  .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PERIPH_DATA_BUS_O(PERIPH_DATA_BUS_O),
  .PERIPH_DATA_BUS_OE(PERIPH_DATA_BUS_OE), .PERIPH_BUS_DIR(PERIPH_BUS_DIR),
  .PERIPH_REG_SELECT(PERIPH_REG_SELECT), .PERIPH_ACCESS_STROBE_N(PERIPH_ACCESS_STROBE_N),
  .PERIPH_READY_N(PERIPH_READY_N), .GENERAL_OUTPUTS(GENERAL_OUTPUTS));

// ---- test/periph_model.sv ----
// Purpose: Eight external peripheral registers on the data bus
// Assumes: Ready line has a pull-up, so it idles high
// Notes:   delay sets how many strobe cycles pass before ready
`timescale 1ns/1ps
module periph_model (
  input  wire logic        clk,
  input  wire logic        strobe_n,
  input  wire logic        bus_dir,
  input  wire logic [2:0]  reg_sel,
  input  wire logic [15:0] dev_data,
  input  wire logic        dev_oe,
  input  wire logic [3:0]  delay,
  output logic             ready_n,
  output logic [15:0]      bus_in
);
  logic [15:0] regs [8];
  logic [15:0] last;
  logic [15:0] wdat;
  logic [3:0]  cnt;
  logic [2:0]  wsel;
  logic        wdir;
  // Shadow the request so the strobe edge never races the pins
  always @(posedge clk) begin
    cnt <= strobe_n ? 4'h0 : cnt + 4'h1;
    last <= bus_in;
    if (!strobe_n) begin
      wdir <= bus_dir;
      wsel <= reg_sel;
      wdat <= dev_data;
    end
  end
  always @(posedge strobe_n) begin
    if (!wdir) regs[wsel] <= wdat;
  end
  assign ready_n = strobe_n | (cnt < delay);
  // Undriven bus shows a changing pattern, never the last value
  assign bus_in = dev_oe ? dev_data : (!strobe_n && bus_dir) ? regs[reg_sel] : ~last;
endmodule

// ---- test/pin_ctrl_tb.sv ----
// Purpose: Self-checking bench for the pin control block
// Assumes: APB master tasks, external peripheral model
// Notes:   One task per scenario
`timescale 1ns/1ps
module pin_ctrl_tb
  import pin_ctrl_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, oe, dir, strobe_n, ready_n, err, halt = 1'b0;
  logic        codec_irq = 1'b0, timer_irq = 1'b0;
  logic [11:0] paddr = 12'h0, pc_h;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] dbus_o, dbus_i;
  logic [2:0]  sel, irq_n = 3'h7;
  logic [1:0]  gin = 2'h0, gout;
  logic [3:0]  delay = 4'h0;
  int          err_count = 0, checks = 0, lowcnt = 0, base;

  pin_ctrl u_pin_ctrl (.CLOCK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PERIPH_DATA_BUS_I(dbus_i), .PERIPH_DATA_BUS_O(dbus_o),
    .PERIPH_DATA_BUS_OE(oe), .PERIPH_BUS_DIR(dir), .PERIPH_REG_SELECT(sel),
    .PERIPH_ACCESS_STROBE_N(strobe_n), .PERIPH_READY_N(ready_n), .HALT(halt),
    .EXT_IRQ_N(irq_n), .CODEC_IRQ(codec_irq), .TIMER_IRQ(timer_irq),
    .GENERAL_INPUTS(gin), .GENERAL_OUTPUTS(gout));
  periph_model u_periph_model (.clk(clk), .strobe_n(strobe_n), .bus_dir(dir),
    .reg_sel(sel), .dev_data(dbus_o), .dev_oe(oe), .delay(delay), .ready_n(ready_n),
    .bus_in(dbus_i));

  // ---------------------------------------------------------------
  // Clock, monitor and shared tasks
  // ---------------------------------------------------------------
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    if (!strobe_n) lowcnt++;
  end

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Holds the request until PREADY is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic acc(input logic w, input logic [2:0] s, input logic [15:0] d);
    lowcnt = 0;
    apb(1'b1, REG_ACCESS, {d, 12'h0, w, s});
    do begin
      apb(1'b0, REG_ACCESS, 32'h0);
    end while (rd[ACC_BUSY_BIT] !== 1'b0);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, REG_CORE, 32'h0);
    cmp("core sp insvc halt page", 32'h40, {20'h0, rd[18:16], rd[13:12], rd[11:8]});
    $display("t_reset done");
  endtask
  task automatic t_bus();
    acc(1'b1, 3'h3, 16'ha5c3);
    cmp("peripheral word", 32'ha5c3, {16'h0, u_periph_model.regs[3]});
    delay <= 4'h6;
    acc(1'b0, 3'h3, 16'h0);
    apb(1'b0, REG_RDATA, 32'h0);
    cmp("read data", 32'ha5c3, {16'h0, rd[15:0]});
    delay <= 4'h0;
    $display("t_bus done");
  endtask
  task automatic t_wait();
    acc(1'b0, 3'h1, 16'h0);
    base = lowcnt;
    apb(1'b1, REG_WAIT, 32'h2);
    acc(1'b0, 3'h1, 16'h0);
    cmp("read strobe length", 32'(base + 1), 32'(lowcnt));
    acc(1'b1, 3'h1, 16'h1234);
    cmp("write strobe length", 32'(base), 32'(lowcnt));
    apb(1'b1, REG_WAIT, 32'h0);
    $display("t_wait done");
  endtask
  task automatic t_refuse();
    apb(1'b1, REG_CTRL, 32'h3);
    acc(1'b0, 3'h5, 16'h0);
    cmp("internal flag and strobe", 32'h8000_0000, {rd[ACC_INTERNAL_BIT], 31'(lowcnt)});
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    cmp("unmapped read", 32'h8000_0000, {err, rd[30:0]});
    $display("t_refuse done");
  endtask
  task automatic t_gpio();
    apb(1'b1, REG_STATUS, 32'h20);
    cmp("general outputs", 32'h2, {30'h0, gout});
    gin <= 2'h2;
    repeat (4) @(posedge clk);
    apb(1'b0, REG_STATUS, 32'h0);
    cmp("general inputs", 32'h2, {30'h0, rd[11:10]});
    $display("t_gpio done");
  endtask
  task automatic t_irq();
    apb(1'b1, REG_VEC + 12'h004, 32'h100);
    apb(1'b1, REG_VEC + 12'h008, 32'h200);
    apb(1'b1, REG_VEC + 12'h00c, 32'h300);
    irq_n <= 3'h0;
    @(posedge clk);
    irq_n <= 3'h7;
    repeat (5) @(posedge clk);
    apb(1'b0, REG_IRQ, 32'h0);
    cmp("pending on release", 32'h7, {29'h0, rd[2:0]});
    apb(1'b1, REG_CTRL, 32'h1c);
    for (int i = 1; i <= 3; i++) begin
      apb(1'b0, REG_CORE, 32'h0);
      cmp("service page", 32'(i), {28'h0, rd[11:8]});
      apb(1'b1, REG_CMD, 32'h1);
    end
    apb(1'b0, REG_IRQ, 32'h0);
    cmp("pending after service", 32'h0, {29'h0, rd[2:0]});
    $display("t_irq done");
  endtask
  task automatic t_halt();
    halt <= 1'b1;
    repeat (3) @(posedge clk);
    halt <= 1'b0;
    apb(1'b0, REG_CORE, 32'h0);
    pc_h = rd[11:0];
    apb(1'b0, REG_CORE, 32'h0);
    cmp("halted pc", {19'h0, 1'b1, pc_h}, {19'h0, rd[12:0]});
    apb(1'b1, REG_CTRL, 32'h1f);
    codec_irq <= 1'b1;
    timer_irq <= 1'b1;
    @(posedge clk);
    codec_irq <= 1'b0;
    timer_irq <= 1'b0;
    apb(1'b0, REG_CORE, 32'h0);
    cmp("codec first", 32'h2, {27'h0, rd[12], rd[11:8]});
    apb(1'b1, REG_CMD, 32'h1);
    apb(1'b0, REG_CORE, 32'h0);
    cmp("timer next", 32'h3, {28'h0, rd[11:8]});
    apb(1'b1, REG_CMD, 32'h1);
    apb(1'b0, REG_CORE, 32'h0);
    cmp("resume after halt", 32'h1, {30'h0, rd[12], (rd[11:0] - pc_h) < 12'h10});
    $display("t_halt done");
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_bus();
    t_wait();
    t_refuse();
    t_gpio();
    t_irq();
    t_halt();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim();
  end
endmodule
